// [include/hbs_pkg.sv]
// Shared constants for the half-bridge fault supervisor
package hbs_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int WORD_W = 16;
    localparam int NUM_SW = 6;
    localparam int CNT_W = 16;

    // ----------------------------------------
    // Command word layout
    // ----------------------------------------
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_SW_LSB = 1;
    localparam int CMD_SHUTDOWN_EN_BIT = 13;
    localparam logic [15:0] CMD_RESET = 16'h2000;

    // ----------------------------------------
    // Status word layout
    // ----------------------------------------
    localparam int ST_PREWARN_BIT = 0;
    localparam int ST_SW_LSB = 1;
    localparam int ST_SHORT_BIT = 13;
    localparam int ST_OPEN_BIT = 14;
    localparam int ST_SUPPLY_BIT = 15;

    // ----------------------------------------
    // Timing (mclk at 8 ns)
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int UV_DELAY_NS = 40000;
    localparam int UV_DELAY_CYC = (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_DELAY_NS = 30000;
    localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SD_DELAY_CYC = 64;

    // ----------------------------------------
    // Synchroniser vector layout
    // ----------------------------------------
    localparam int SYN_W = 19;
    localparam logic [18:0] SYN_RESET = 19'h40000;
endpackage

// [design/hbs_supervisor.sv]
// Fault supervisor and serial command/status port of a triple half-bridge driver
//
// Behaviour
// RULE1: Undervoltage sets supply-fail flag, disables all outputs
// RULE2: Undervoltage counts only after persisting past delay
// RULE3: Outputs return at once when supply recovers
// RULE4: Supply-fail flag latched until latch-clear written
// RULE5: Open-load flag set on low current, switch on
// RULE6: Open-load flag latched until latch-clear written
// RULE7: Open load reported only after detection delay
// RULE8: Prewarning flag follows set/release hysteresis thresholds
// RULE9: Prewarning flag drives data out at select fall
// RULE10: Short select frame aborts, registers unchanged
// RULE11: Thermal shutdown disables outputs, clears switch status
// RULE12: Thermal restart needs cool down plus latch-clear
// RULE13: Overcurrent turn-off only while enable bit high
// RULE14: Overcurrent switch turned off after shutdown delay
// RULE15: Overcurrent turn-off sets short flag, clears status
// RULE16: Disabled shutdown still flags short, outputs kept
// RULE17: Latch-clear clears short flag, restores tripped switches
// RULE18: Inhibit low turns off and tristates all switches
// RULE19: Inhibit erases the status register
// RULE20: Inhibit release starts internal power-on reset
// RULE21: Status word bit positions fixed as listed
// RULE22: Switch status shows on state, ignores clear
// RULE23: Command reset: shutdown enable high, rest low
// RULE24: Command switch bit high turns switch on
// RULE25: Detection delays are parameterised cycle counters
// RULE26: Analog detectors arrive as synchronised inputs
`timescale 1ns/1ps
`default_nettype none

module hbs_supervisor #(
    parameter int unsigned UV_DELAY_CYCLES = hbs_pkg::UV_DELAY_CYC,
    parameter int unsigned SD_DELAY_CYCLES = hbs_pkg::SD_DELAY_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic inhibit_input,
    input wire logic uv_detect,
    input wire logic prewarn_set_threshold,
    input wire logic prewarn_release_threshold,
    input wire logic tsd_detect,
    input wire logic [5:0] open_load_detect,
    input wire logic [5:0] overcurrent_detect,
    output logic [5:0] switch_on,
    output logic [5:0] switch_oe,
    output logic [15:0] status_word
);

    // ----------------------------------------
    // Link domain (serial_clk)
    // ----------------------------------------

    logic [4:0] link_cnt_reg;
    logic [15:0] link_shift_reg;
    logic [15:0] link_word_reg;
    logic link_tgl_reg;
    logic frame_clr;
    logic [15:0] status_snap_reg;
    logic temp_prewarn_flag_reg;

    // Deselect ends the frame without needing a clock edge
    assign frame_clr = chip_select_n | sys_rst;

    // Bit counter and input shift, LSB first
    always_ff @(posedge serial_clk or posedge frame_clr) begin
        if (frame_clr) begin
            link_cnt_reg <= 5'h00;
            link_shift_reg <= 16'h0000;
        end else begin
            link_shift_reg <= {serial_data_in, link_shift_reg[15:1]};
            if (link_cnt_reg != 5'h10) begin
                link_cnt_reg <= link_cnt_reg + 5'h01;
            end
        end
    end

    // Full word captured at the 16th edge; toggle tells mclk side
    always_ff @(posedge serial_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_word_reg <= 16'h0000;
            link_tgl_reg <= 1'b0;
        end else if (!chip_select_n && link_cnt_reg == 5'h0f) begin
            link_word_reg <= {serial_data_in, link_shift_reg[15:1]};
            link_tgl_reg <= ~link_tgl_reg;
        end
    end

    // Prewarning bit is live before the first edge, snapshot after
    always_comb begin
        if (link_cnt_reg == 5'h00) begin
            serial_data_out = temp_prewarn_flag_reg; // see RULE9
        end else if (link_cnt_reg == 5'h10) begin
            serial_data_out = 1'b0;
        end else begin
            serial_data_out = status_snap_reg[link_cnt_reg[3:0]];
        end
    end

    // Data out is driven only while selected
    assign serial_data_oe = ~chip_select_n;

    // ----------------------------------------
    // Input synchronisers (mclk)
    // ----------------------------------------

    logic [hbs_pkg::SYN_W-1:0] syn1_reg;
    logic [hbs_pkg::SYN_W-1:0] syn2_reg;
    logic [hbs_pkg::SYN_W-1:0] syn_raw;

    // Select, inhibit, detector pins and the link toggle go through two flops; the link word is read directly
    assign syn_raw = {chip_select_n, link_tgl_reg, inhibit_input, uv_detect,
                      prewarn_set_threshold, prewarn_release_threshold, tsd_detect,
                      open_load_detect, overcurrent_detect};

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            syn1_reg <= hbs_pkg::SYN_RESET;
            syn2_reg <= hbs_pkg::SYN_RESET;
        end else begin
            syn1_reg <= syn_raw; // see RULE26
            syn2_reg <= syn1_reg;
        end
    end

    logic cs_s;
    logic tgl_s;
    logic inhibit_s;
    logic uv_s;
    logic pw_set_s;
    logic pw_rel_s;
    logic tsd_s;
    logic [5:0] ol_s;
    logic [5:0] oc_s;

    assign cs_s = syn2_reg[18];
    assign tgl_s = syn2_reg[17];
    assign inhibit_s = syn2_reg[16];
    assign uv_s = syn2_reg[15];
    assign pw_set_s = syn2_reg[14];
    assign pw_rel_s = syn2_reg[13];
    assign tsd_s = syn2_reg[12];
    assign ol_s = syn2_reg[11:6];
    assign oc_s = syn2_reg[5:0];

    // ----------------------------------------
    // Inhibit and internal power-on reset
    // ----------------------------------------

    logic [15:0] por_cnt_reg;
    logic soft_rst;

    // Inhibit holds the count loaded; release lets it run down
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            por_cnt_reg <= 16'(hbs_pkg::POR_DELAY_CYC);
        end else if (!inhibit_s) begin
            por_cnt_reg <= 16'(hbs_pkg::POR_DELAY_CYC); // see RULE20
        end else if (por_cnt_reg != 16'h0000) begin
            por_cnt_reg <= por_cnt_reg - 16'h0001;
        end
    end

    assign soft_rst = !inhibit_s || (por_cnt_reg != 16'h0000);

    // ----------------------------------------
    // Command commit
    // ----------------------------------------

    logic cs_d_reg;
    logic tgl_d_reg;
    logic word_pend_reg;
    logic commit;
    logic latch_clear_command;
    logic [15:0] cmd_reg;
    logic overcurrent_shutdown_enable;

    // Word only counts if it fully arrived before deselect
    assign commit = cs_s && !cs_d_reg && word_pend_reg; // see RULE10

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_d_reg <= 1'b1;
            tgl_d_reg <= 1'b0;
            word_pend_reg <= 1'b0;
        end else begin
            cs_d_reg <= cs_s;
            tgl_d_reg <= tgl_s;
            if (tgl_s != tgl_d_reg) begin
                word_pend_reg <= 1'b1;
            end else if (cs_s && !cs_d_reg) begin
                word_pend_reg <= 1'b0;
            end
        end
    end

    // Command register; power-on value reloaded during inhibit
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_reg <= hbs_pkg::CMD_RESET;
        end else if (soft_rst) begin
            cmd_reg <= hbs_pkg::CMD_RESET; // see RULE23
        end else if (commit) begin
            cmd_reg <= link_word_reg;
        end
    end

    // Clear acts once, as the word lands
    assign latch_clear_command = commit && link_word_reg[hbs_pkg::CMD_CLEAR_BIT];
    assign overcurrent_shutdown_enable = cmd_reg[hbs_pkg::CMD_SHUTDOWN_EN_BIT];

    // ----------------------------------------
    // Undervoltage
    // ----------------------------------------

    logic [15:0] uv_cnt_reg;
    logic uv_active;
    logic supply_fail_flag_reg;

    // Dips shorter than the delay never reach the limit
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            uv_cnt_reg <= 16'h0000;
        end else if (!uv_s) begin
            uv_cnt_reg <= 16'h0000; // see RULE3
        end else if (uv_cnt_reg != 16'(UV_DELAY_CYCLES)) begin
            uv_cnt_reg <= uv_cnt_reg + 16'h0001; // see RULE2, RULE25
        end
    end

    assign uv_active = uv_s && (uv_cnt_reg == 16'(UV_DELAY_CYCLES));

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            supply_fail_flag_reg <= 1'b0;
        end else if (soft_rst) begin
            supply_fail_flag_reg <= 1'b0; // see RULE19
        end else if (uv_active) begin
            supply_fail_flag_reg <= 1'b1; // see RULE1
        end else if (latch_clear_command) begin
            supply_fail_flag_reg <= 1'b0; // see RULE4
        end
    end

    // ----------------------------------------
    // Open load
    // ----------------------------------------

    logic [15:0] ol_cnt_reg;
    logic ol_cond;
    logic ol_hit;
    logic open_load_flag_reg;
    logic [5:0] switch_on_reg;

    assign ol_cond = |(ol_s & switch_on_reg); // see RULE5

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ol_cnt_reg <= 16'h0000;
        end else if (!ol_cond) begin
            ol_cnt_reg <= 16'h0000;
        end else if (ol_cnt_reg != 16'(SD_DELAY_CYCLES)) begin
            ol_cnt_reg <= ol_cnt_reg + 16'h0001; // see RULE7, RULE25
        end
    end

    assign ol_hit = ol_cond && (ol_cnt_reg == 16'(SD_DELAY_CYCLES));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            open_load_flag_reg <= 1'b0;
        end else if (soft_rst) begin
            open_load_flag_reg <= 1'b0; // see RULE19
        end else if (ol_hit) begin
            open_load_flag_reg <= 1'b1; // see RULE5
        end else if (latch_clear_command) begin
            open_load_flag_reg <= 1'b0; // see RULE6
        end
    end

    // ----------------------------------------
    // Temperature
    // ----------------------------------------

    logic tsd_latch_reg;

    // Hysteresis lives in the two comparators; release beats nothing
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            temp_prewarn_flag_reg <= 1'b0;
        end else if (soft_rst) begin
            temp_prewarn_flag_reg <= 1'b0;
        end else if (pw_set_s) begin
            temp_prewarn_flag_reg <= 1'b1; // see RULE8
        end else if (pw_rel_s) begin
            temp_prewarn_flag_reg <= 1'b0; // see RULE8
        end
    end

    // Restart needs both a cool die and a clear command
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tsd_latch_reg <= 1'b0;
        end else if (soft_rst) begin
            tsd_latch_reg <= 1'b0;
        end else if (tsd_s) begin
            tsd_latch_reg <= 1'b1; // see RULE11
        end else if (latch_clear_command) begin
            tsd_latch_reg <= 1'b0; // see RULE12
        end
    end

    // ----------------------------------------
    // Overcurrent, one delay counter per switch
    // ----------------------------------------

    logic [15:0] oc_cnt_reg [6];
    logic [5:0] oc_hit;
    logic [5:0] oc_off_reg;
    logic short_circuit_flag_reg;

    for (genvar i = 0; i < hbs_pkg::NUM_SW; i++) begin : g_oc
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                oc_cnt_reg[i] <= 16'h0000;
            end else if (!(oc_s[i] && switch_on_reg[i])) begin
                oc_cnt_reg[i] <= 16'h0000;
            end else if (oc_cnt_reg[i] != 16'(SD_DELAY_CYCLES)) begin
                oc_cnt_reg[i] <= oc_cnt_reg[i] + 16'h0001; // see RULE14
            end
        end
        assign oc_hit[i] = oc_s[i] && switch_on_reg[i] &&
                           (oc_cnt_reg[i] == 16'(SD_DELAY_CYCLES));
    end

    // Trips only with shutdown enabled; clear wins nothing over a new trip
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_off_reg <= 6'h00;
        end else if (soft_rst) begin
            oc_off_reg <= 6'h00;
        end else if (overcurrent_shutdown_enable) begin
            oc_off_reg <= oc_hit | (latch_clear_command ? 6'h00 : oc_off_reg); // see RULE13, RULE17
        end else if (latch_clear_command) begin
            oc_off_reg <= 6'h00; // see RULE17
        end
    end

    // Short flag is raised whether or not shutdown is enabled
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            short_circuit_flag_reg <= 1'b0;
        end else if (soft_rst) begin
            short_circuit_flag_reg <= 1'b0;
        end else if (|oc_hit) begin
            short_circuit_flag_reg <= 1'b1; // see RULE15, RULE16
        end else if (latch_clear_command) begin
            short_circuit_flag_reg <= 1'b0; // see RULE17
        end
    end

    // ----------------------------------------
    // Switch drive and status
    // ----------------------------------------

    logic [5:0] switch_on_next;
    logic global_off;

    assign global_off = soft_rst || uv_active || tsd_latch_reg; // see RULE1, RULE11

    // Tripped switches stay off; others follow the command bits
    always_comb begin
        switch_on_next = cmd_reg[hbs_pkg::CMD_SW_LSB +: 6] & ~oc_off_reg; // see RULE24, RULE15
        if (global_off) begin
            switch_on_next = 6'h00;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            switch_on_reg <= 6'h00;
            switch_oe <= 6'h00;
        end else begin
            switch_on_reg <= switch_on_next; // see RULE22
            switch_oe <= inhibit_s ? 6'h3f : 6'h00; // see RULE18
        end
    end

    assign switch_on = switch_on_reg;

    // Status word assembled from flags and actual switch states
    always_comb begin
        status_word = 16'h0000;
        status_word[hbs_pkg::ST_PREWARN_BIT] = temp_prewarn_flag_reg; // see RULE21
        status_word[hbs_pkg::ST_SW_LSB +: 6] = switch_on_reg;
        status_word[hbs_pkg::ST_SHORT_BIT] = short_circuit_flag_reg;
        status_word[hbs_pkg::ST_OPEN_BIT] = open_load_flag_reg;
        status_word[hbs_pkg::ST_SUPPLY_BIT] = supply_fail_flag_reg;
    end

    // Snapshot frozen while selected so the link reads a stable word
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            status_snap_reg <= 16'h0000;
        end else if (cs_s) begin
            status_snap_reg <= status_word;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_uv_sets_flag: assert property (uv_active && !soft_rst |=> supply_fail_flag_reg) // see RULE1
        else $error("undervoltage did not set supply fail");
    a_uv_delay_len: assert property ($rose(supply_fail_flag_reg) |-> // see RULE2
                                     $past(uv_s) && $past(uv_cnt_reg) == 16'(UV_DELAY_CYCLES))
        else $error("undervoltage recognised early");
    a_uv_outputs_off: assert property (uv_active |=> switch_on_reg == 6'h00) // see RULE1
        else $error("switch on during undervoltage");
    a_supply_fail_held: assert property (supply_fail_flag_reg && !soft_rst // see RULE4
                                         && !latch_clear_command |=> supply_fail_flag_reg)
        else $error("supply fail dropped without clear");
    a_tsd_outputs_off: assert property (tsd_s && !soft_rst |=> ##1 switch_on_reg == 6'h00) // see RULE11
        else $error("switch on after thermal shutdown");
    a_short_flagged: assert property ((|oc_hit) && !soft_rst |=> short_circuit_flag_reg) // see RULE16
        else $error("overcurrent did not set short flag");
    a_no_trip_disabled: assert property (!overcurrent_shutdown_enable // see RULE13
                                         |=> (oc_off_reg & ~$past(oc_off_reg)) == 6'h00)
        else $error("switch tripped with shutdown disabled");
    a_inhibit_erase: assert property (!inhibit_s |=> status_word == 16'h0000 && switch_oe == 6'h00) // see RULE19
        else $error("status not erased in inhibit");
    a_abort_keeps_cmd: assert property (cs_s && !cs_d_reg && !word_pend_reg // see RULE10
                                        && !soft_rst |=> $stable(cmd_reg))
        else $error("short frame changed command");
    a_prewarn_set: assert property (pw_set_s && !soft_rst |=> temp_prewarn_flag_reg) // see RULE8
        else $error("prewarning not set");

    c_word_commit: cover property (commit);
    c_uv_event: cover property ($rose(uv_active));
    c_oc_trip: cover property (|oc_hit && overcurrent_shutdown_enable);
    c_short_frame: cover property (cs_s && !cs_d_reg && !word_pend_reg);

endmodule // hbs_supervisor

`default_nettype wire

// [dv/hbs_host_model.sv]
// Behavioural host driving the serial command/status link
`timescale 1ns/1ps
`default_nettype none

module hbs_host_model (
    output logic serial_clk,
    output logic chip_select_n,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe
);
    logic [15:0] rd_word;
    logic first_bit;
    logic oe_seen;

    // Link clock idles low between frames
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
        rd_word = 16'h0000;
        first_bit = 1'b0;
        oe_seen = 1'b0;
    end

    // One frame, LSB first, 125 ns link period; nbits below 16 aborts early
    task automatic frame(input logic [15:0] cmd, input int nbits);
        chip_select_n = 1'b0;
        #40;
        first_bit = serial_data_out;
        oe_seen = serial_data_oe;
        for (int k = 0; k < nbits; k++) begin
            serial_data_in = cmd[k];
            #22.5;
            rd_word[k] = serial_data_out;
            serial_clk = 1'b1;
            #62.5;
            serial_clk = 1'b0;
            #40;
        end
        chip_select_n = 1'b1;
        // Released line must not keep showing the last bit
        serial_data_in = ~serial_data_in;
        #100;
    endtask
endmodule // hbs_host_model
`default_nettype wire

// [dv/hbs_supervisor_bench.sv]
// Self-checking bench for the half-bridge fault supervisor
`timescale 1ns/1ps
`default_nettype none

module hbs_supervisor_bench;
    typedef struct packed {
        logic [15:0] cmd;
        logic [5:0] sw;
    } hbs_row_t;
    logic mclk, sys_rst, inhibit_input, uv_detect, tsd_detect;
    logic prewarn_set_threshold, prewarn_release_threshold;
    logic [5:0] open_load_detect, overcurrent_detect, prev;
    wire logic serial_clk, chip_select_n, serial_data_in, serial_data_out, serial_data_oe;
    wire logic [5:0] switch_on, switch_oe;
    wire logic [15:0] status_word;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    hbs_row_t rows [4] = '{'{16'h2002, 6'h01}, '{16'h207e, 6'h3f},
                           '{16'h2054, 6'h2a}, '{16'h202a, 6'h15}};

    hbs_supervisor #(.UV_DELAY_CYCLES(20), .SD_DELAY_CYCLES(8)) DUT (
        .mclk(mclk), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
        .inhibit_input(inhibit_input), .uv_detect(uv_detect),
        .prewarn_set_threshold(prewarn_set_threshold),
        .prewarn_release_threshold(prewarn_release_threshold),
        .tsd_detect(tsd_detect), .open_load_detect(open_load_detect),
        .overcurrent_detect(overcurrent_detect), .switch_on(switch_on),
        .switch_oe(switch_oe), .status_word(status_word)
    );

    hbs_host_model HOST (
        .serial_clk(serial_clk), .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe)
    );

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Two power-on waits plus thirteen frames fit well inside this
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs always move 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Full frame, then room for the commit to land
    task automatic send(input logic [15:0] cmd);
        HOST.frame(cmd, 16);
        step(8);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        inhibit_input = 1'b1;
        uv_detect = 1'b0;
        tsd_detect = 1'b0;
        prewarn_set_threshold = 1'b0;
        prewarn_release_threshold = 1'b1;
        open_load_detect = 6'h00;
        overcurrent_detect = 6'h00;
        repeat (5) @(posedge mclk);
        #1 sys_rst = 1'b0;
        step(3800);
        check(switch_on, 6'h00);
        check(switch_oe, 6'h3f);
        check(status_word, 16'h0000);
        done("power_on");
        // Status read in each frame reflects the previous command
        prev = 6'h00;
        foreach (rows[i]) begin
            send(rows[i].cmd);
            check(HOST.rd_word, {9'h000, prev, 1'b0});
            check(switch_on, rows[i].sw);
            check(status_word[6:1], rows[i].sw);
            prev = rows[i].sw;
        end
        done("table");
        prewarn_release_threshold = 1'b0;
        prewarn_set_threshold = 1'b1;
        step(4);
        check(status_word[0], 1'b1);
        HOST.frame(16'h0000, 3);
        step(8);
        check(HOST.first_bit, 1'b1);
        check(HOST.oe_seen, 1'b1);
        check(serial_data_oe, 1'b0);
        check(switch_on, 6'h15);
        prewarn_set_threshold = 1'b0;
        step(4);
        check(status_word[0], 1'b1);
        prewarn_release_threshold = 1'b1;
        step(4);
        check(status_word[0], 1'b0);
        done("prewarn");
        uv_detect = 1'b1;
        step(10);
        uv_detect = 1'b0;
        step(30);
        check(status_word[15], 1'b0);
        uv_detect = 1'b1;
        step(30);
        check(status_word[15], 1'b1);
        check(switch_on, 6'h00);
        uv_detect = 1'b0;
        step(4);
        check(switch_on, 6'h15);
        check(status_word[15], 1'b1);
        send(16'h202b);
        check(status_word[15], 1'b0);
        done("undervoltage");
        open_load_detect = 6'h01;
        step(5);
        check(status_word[14], 1'b0);
        step(20);
        check(status_word[14], 1'b1);
        open_load_detect = 6'h00;
        step(4);
        check(status_word[14], 1'b1);
        send(16'h202b);
        check(status_word[14], 1'b0);
        done("open_load");
        overcurrent_detect = 6'h04;
        step(5);
        check(switch_on, 6'h15);
        step(20);
        check(switch_on, 6'h11);
        check(status_word[13], 1'b1);
        check(status_word[3], 1'b0);
        overcurrent_detect = 6'h00;
        send(16'h202b);
        check(switch_on, 6'h15);
        check(status_word[13], 1'b0);
        send(16'h002a);
        overcurrent_detect = 6'h04;
        step(25);
        check(status_word[13], 1'b1);
        check(switch_on, 6'h15);
        overcurrent_detect = 6'h00;
        send(16'h202b);
        done("overcurrent");
        tsd_detect = 1'b1;
        step(5);
        check(switch_on, 6'h00);
        check(status_word[6:1], 6'h00);
        send(16'h202b);
        check(switch_on, 6'h00);
        tsd_detect = 1'b0;
        step(4);
        check(switch_on, 6'h00);
        send(16'h202b);
        check(switch_on, 6'h15);
        done("thermal");
        inhibit_input = 1'b0;
        step(5);
        check(switch_oe, 6'h00);
        check(switch_on, 6'h00);
        check(status_word, 16'h0000);
        inhibit_input = 1'b1;
        step(3800);
        check(switch_oe, 6'h3f);
        check(switch_on, 6'h00);
        send(16'h2002);
        check(switch_on, 6'h01);
        done("inhibit");
        complete_run();
    end
endmodule // hbs_supervisor_bench
`default_nettype wire
